// ### design/fpt_pkg.sv
// fpt_pkg: constants and carrier types for the four-channel fan pwm and tach monitor
package fpt_pkg;
	// ==========================================================
	// channel layout
	localparam int NUM_FANS = 4;
	localparam int PWR_W    = 7;
	localparam logic [6:0] PWR_FULL = 7'h64;
	// ==========================================================
	// timing, 40 MHz clock
	localparam longint CLK_HZ       = 40000000;
	localparam longint PWM_HZ       = 18;
	localparam longint MEAS_MS      = 125;
	localparam longint ROTATE_MS    = 500;
	localparam longint STAGGER_MS   = 500;
	localparam longint PWM_CYCLES     = CLK_HZ / PWM_HZ;
	localparam longint STEP_CYCLES    = PWM_CYCLES / 100;
	localparam longint MEAS_CYCLES    = CLK_HZ * MEAS_MS / 1000;
	localparam longint SLOT_CYCLES    = CLK_HZ * ROTATE_MS / 1000 / NUM_FANS;
	localparam longint STAGGER_CYCLES = CLK_HZ * STAGGER_MS / 1000;
	localparam longint TICK_HZ        = 27692308 / 1000 * 1000;
	// ==========================================================
	// speed report carrier
	typedef struct packed {
		logic [1:0]  fan;
		logic [7:0]  cycles;
		logic [15:0] ticks;
	} fpt_report_t;
endpackage

// ### design/fpt_sync.sv
// fpt_sync: two-flop synchroniser for one bit
`timescale 1ns/1ps
`default_nettype none
module fpt_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ce,
	// data
	input  wire logic d,
	output logic      q
);
	logic meta;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b1;
			q    <= 1'b1;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// ### design/fpt_top.sv
// fpt_top: four fan pwm switches with round-robin tach measurement
// How it works
// R1: four channels, each with switch output and tach input
// R2: power setting 0 to 100 percent per channel
// R3: setting drives duty of low-side open-drain switch
// R4: pwm period is one eighteenth of a second
// R5: tach frequency averaged over a 125 ms window
// R6: one fan measured at a time, each refreshed every 500 ms
// R7: reporting fan forced full on at window start
// R8: force held until glitch delay expired and two tach edges seen
// R9: stretched on pulse never exceeds 125 ms
// R10: no stretch at full power or when pwm already on; code forces at each reporting window start whatever the pwm state
// R11: fail-safe fan goes full when host refresh times out
// R12: host should keep duty above twenty percent, ideally 30-40
// R13: power-up setting from boot state else full power
// R14: enabled fans start one after another, 500 ms apart
// R15: report carries fan index, tach cycles, 16-bit tick count
// R16: zero means always off, full means always on
// R17: fans not reporting are never stretched
`timescale 1ns/1ps
`default_nettype none
module fpt_top #(
	parameter int PWM_CYC     = int'(fpt_pkg::PWM_CYCLES),
	parameter int MEAS_CYC    = int'(fpt_pkg::MEAS_CYCLES),
	parameter int SLOT_CYC    = int'(fpt_pkg::SLOT_CYCLES),
	parameter int STAGGER_CYC = int'(fpt_pkg::STAGGER_CYCLES),
	parameter int TICK_DIV    = 1
) (
	// clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    ce,
	// host settings
	input  wire logic [3:0][6:0]         power,
	input  wire logic                    power_wr,
	input  wire logic                    boot_valid,
	input  wire logic [3:0][6:0]         boot_power,
	input  wire logic [3:0]              fan_on_boot,
	input  wire logic [3:0]              report_en,
	input  wire logic [3:0]              failsafe_en,
	input  wire logic [31:0]             failsafe_cyc,
	input  wire logic [15:0]             glitch_cyc,
	// fan pins
	input  wire logic [3:0]              tach,
	output logic      [3:0]              sw_out,
	output logic      [3:0]              sw_oe,
	// speed report
	output fpt_pkg::fpt_report_t         report,
	output logic                         report_valid,
	output logic      [3:0]              failsafe_active
);
	localparam int N = fpt_pkg::NUM_FANS;

	if (N != 4 || PWM_CYC < 100 || MEAS_CYC < 2 || SLOT_CYC < MEAS_CYC
		|| STAGGER_CYC < 1 || TICK_DIV < 1) begin : g_bad_param
		$error("fpt_top: bad timing parameters");
	end

	// ==========================================================
	// tach synchronisers and edge detect
	logic [3:0] tach_s;
	logic [3:0] tach_d;
	genvar g;
	for (g = 0; g < N; g++) begin : g_sync
		fpt_sync u_sync (.clk(clk), .rst_b(rst_b), .ce(ce), .d(tach[g]), .q(tach_s[g]));
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) tach_d <= 4'hF;
		else if (ce) tach_d <= tach_s;
	end
	wire [3:0] tach_edge = tach_s & ~tach_d;

	// ==========================================================
	// power-up load and staggered start
	logic [3:0][6:0] setting;
	logic [3:0]      started;
	logic [1:0]      start_idx;
	logic [31:0]     stagger_cnt;
	logic            loaded;
	logic            start_done;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			setting <= '0;
			loaded  <= 1'b0;
		end else if (ce) begin
			// R13: boot load
			if (!loaded) begin
				loaded <= 1'b1;
				for (int i = 0; i < N; i++)
					setting[i] <= boot_valid ? boot_power[i] : fpt_pkg::PWR_FULL;
			end else if (power_wr) begin
				for (int i = 0; i < N; i++)
					setting[i] <= (power[i] > fpt_pkg::PWR_FULL) ? fpt_pkg::PWR_FULL : power[i];
			end
		end
	end
	// R14: one fan every stagger period, only enabled fans wait
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			started     <= 4'h0;
			start_idx   <= 2'h0;
			stagger_cnt <= 32'h0;
			start_done  <= 1'b0;
		end else if (ce && loaded && !start_done) begin
			if (stagger_cnt != 32'h0) begin
				stagger_cnt <= stagger_cnt - 32'h1;
			end else begin
				started[start_idx] <= fan_on_boot[start_idx];
				if (fan_on_boot[start_idx])
					stagger_cnt <= 32'(STAGGER_CYC - 1);
				start_idx <= start_idx + 2'h1;
				if (start_idx == 2'(N - 1))
					start_done <= 1'b1;
			end
		end
	end

	// ==========================================================
	// fail-safe watchdog
	logic [31:0] fs_cnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fs_cnt          <= 32'h0;
			failsafe_active <= 4'h0;
		end else if (ce) begin
			// R11: refresh timeout forces full power
			if (power_wr) begin
				fs_cnt          <= 32'h0;
				failsafe_active <= 4'h0;
			end else if (failsafe_cyc != 32'h0 && fs_cnt >= failsafe_cyc) begin
				failsafe_active <= failsafe_en;
			end else begin
				fs_cnt <= fs_cnt + 32'h1;
			end
		end
	end

	// ==========================================================
	// pwm base counter and per-channel compare
	logic [31:0] pwm_cnt;
	logic [6:0]  pwm_step;
	logic [31:0] step_cnt;
	// R4: 18 Hz period split into 100 steps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			step_cnt <= 32'h0;
			pwm_step <= 7'h0;
		end else if (ce) begin
			if (step_cnt >= 32'(PWM_CYC / 100 - 1)) begin
				step_cnt <= 32'h0;
				pwm_step <= (pwm_step == 7'(99)) ? 7'h0 : pwm_step + 7'h1;
			end else begin
				step_cnt <= step_cnt + 32'h1;
			end
		end
	end

	// ==========================================================
	// measurement rotation
	logic [1:0]  meas_fan;
	logic [31:0] slot_cnt;
	logic        forcing;
	logic [1:0]  force_edges;
	logic [15:0] glitch_cnt;
	logic [7:0]  tach_cycles;
	logic [15:0] ticks;
	logic [31:0] tick_div;
	wire in_window = slot_cnt < 32'(MEAS_CYC);
	wire win_start = slot_cnt == 32'h0;
	wire win_end   = slot_cnt == 32'(MEAS_CYC - 1);
	// R6: fixed slot per fan, four slots per 500 ms
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_cnt <= 32'h0;
			meas_fan <= 2'h0;
		end else if (ce) begin
			if (slot_cnt == 32'(SLOT_CYC - 1)) begin
				slot_cnt <= 32'h0;
				meas_fan <= meas_fan + 2'h1;
			end else begin
				slot_cnt <= slot_cnt + 32'h1;
			end
		end
	end
	// R7: force at window start for reporting fans only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			forcing     <= 1'b0;
			force_edges <= 2'h0;
			glitch_cnt  <= 16'h0;
		end else if (ce) begin
			if (win_start && report_en[meas_fan]) begin
				forcing     <= 1'b1;
				force_edges <= 2'h0;
				glitch_cnt  <= glitch_cyc;
			end else if (forcing) begin
				if (glitch_cnt != 16'h0)
					glitch_cnt <= glitch_cnt - 16'h1;
				if (tach_edge[meas_fan] && force_edges != 2'h2)
					force_edges <= force_edges + 2'h1;
				// R8: release after glitch delay and two edges
				// R9: never past the window
				if ((glitch_cnt == 16'h0 && force_edges == 2'h2) || win_end)
					forcing <= 1'b0;
			end
		end
	end
	// R5: count tach cycles and ticks across the window
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tach_cycles  <= 8'h0;
			ticks        <= 16'h0;
			tick_div     <= 32'h0;
			report       <= '0;
			report_valid <= 1'b0;
		end else if (ce) begin
			report_valid <= 1'b0;
			if (win_start) begin
				tach_cycles <= 8'h0;
				ticks       <= 16'h0;
				tick_div    <= 32'h0;
			end else if (in_window) begin
				if (tach_edge[meas_fan] && tach_cycles != 8'hFE)
					tach_cycles <= tach_cycles + 8'h1;
				if (tick_div >= 32'(TICK_DIV - 1)) begin
					tick_div <= 32'h0;
					if (ticks != 16'hFFFF)
						ticks <= ticks + 16'h1;
				end else begin
					tick_div <= tick_div + 32'h1;
				end
			end
			// R15: report fan index, cycles, ticks
			if (win_end && report_en[meas_fan]) begin
				report.fan    <= meas_fan;
				report.cycles <= tach_cycles;
				report.ticks  <= ticks;
				report_valid  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// switch drive, open drain low side
	for (g = 0; g < N; g++) begin : g_sw
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				sw_oe[g]  <= 1'b0;
				sw_out[g] <= 1'b0;
			end else if (ce) begin
				sw_out[g] <= 1'b0;
				// R1: each channel independent
				// R2: R3: R16: duty from setting, 0 off, 100 on
				// R10: R17: stretch only when forcing this reporting fan
				sw_oe[g] <= started[g] && (failsafe_active[g]
					|| (pwm_step < setting[g])
					|| (forcing && meas_fan == 2'(g) && report_en[g]));
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/fpt_fan.sv
// fpt_fan: tach source of one fan
`timescale 1ns/1ps
`default_nettype none
module fpt_fan #(parameter int HALF = 7) (
	input  wire logic clk,
	input  wire logic on,
	output logic      tach
);
	int n = 0;
	initial tach = 1'b1;
	always @(posedge clk) begin
		n <= on && n < HALF ? n + 1 : 0;
		tach <= !on || (n == HALF ? ~tach : tach);
	end
endmodule
`default_nettype wire

// ### tb/fpt_top_sva.sv
// fpt_top_sva: port checks
`timescale 1ns/1ps
`default_nettype none
module fpt_top_sva #(parameter int SLOT_CYC = 400, parameter int STAGGER_CYC = 50) (
	input wire logic                 clk,
	input wire logic                 rst_b,
	input wire logic                 ce,
	input wire logic                 power_wr,
	input wire logic [3:0]           fan_on_boot,
	input wire logic [3:0]           report_en,
	input wire logic [3:0]           sw_out,
	input wire logic [3:0]           sw_oe,
	input wire fpt_pkg::fpt_report_t report,
	input wire logic                 report_valid,
	input wire logic [3:0]           failsafe_active
);
	logic [3:0] re_q;
	int         gap;
	int         age;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ====
	// report gap and age
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			re_q <= 4'h0;
			gap <= SLOT_CYC;
			age <= 0;
		end else begin
			re_q <= report_en;
			gap <= report_valid ? 1 : gap + 32'(gap < SLOT_CYC);
			age <= age + 32'(age < 4 * STAGGER_CYC);
		end
	end
	property p_sw_data; sw_out == 4'h0; endproperty
	a_sw_data: assert property (p_sw_data) else $error("data high");
	property p_rv_pulse; report_valid |=> !report_valid; endproperty
	a_rv_pulse: assert property (p_rv_pulse) else $error("long pulse");
	property p_fs_clear; ce && power_wr |=> failsafe_active == 4'h0; endproperty
	a_fs_clear: assert property (p_fs_clear) else $error("not cleared");
	property p_fs_full;
		ce && failsafe_active[0] && fan_on_boot[0] && age > 4 |=> sw_oe[0];
	endproperty
	a_fs_full: assert property (p_fs_full) else $error("not full");
	property p_ce_hold;
		!ce |=> $stable(sw_oe) && $stable(report_valid) && $stable(failsafe_active)
			&& $stable(report);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("moved while frozen"); // clock enable
	property p_rv_fan; report_valid |-> re_q[report.fan]; endproperty
	a_rv_fan: assert property (p_rv_fan) else $error("bad fan");
	property p_rv_gap; report_valid |-> gap >= SLOT_CYC; endproperty
	a_rv_gap: assert property (p_rv_gap) else $error("too soon");
	property p_stag; sw_oe[3] |-> age >= STAGGER_CYC * $countones(fan_on_boot[2:0]); endproperty
	a_stag: assert property (p_stag) else $error("early start");
	property p_boot_only; (sw_oe & ~fan_on_boot) == 4'h0; endproperty
	a_boot_only: assert property (p_boot_only) else $error("idle fan on");
endmodule
bind fpt_top fpt_top_sva #(.SLOT_CYC(SLOT_CYC), .STAGGER_CYC(STAGGER_CYC)) chk_u (
	.clk(clk), .rst_b(rst_b), .ce(ce), .power_wr(power_wr), .fan_on_boot(fan_on_boot),
	.report_en(report_en), .sw_out(sw_out), .sw_oe(sw_oe), .report(report),
	.report_valid(report_valid), .failsafe_active(failsafe_active));
`default_nettype wire

// ### tb/tb_fan_pwm_tach_monitor.sv
// tb_fan_pwm_tach_monitor: bench for fpt_top
`timescale 1ns/1ps
`default_nettype none
module tb_fan_pwm_tach_monitor;
	localparam int PWM = 1000;
	localparam int SLOT = 400;
	logic clk, rst_b, ce, power_wr, boot_valid, report_valid;
	logic [3:0][6:0] power, boot_power;
	logic [3:0] fan_on_boot, report_en, failsafe_en, sw_oe, failsafe_active;
	logic [31:0] failsafe_cyc;
	logic [15:0] glitch_cyc;
	wire [3:0] tach;
	fpt_pkg::fpt_report_t report;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	int set_q [4];
	fpt_top #(.PWM_CYC(PWM), .MEAS_CYC(200), .SLOT_CYC(SLOT), .STAGGER_CYC(50)) dut_u (
		.clk(clk), .rst_b(rst_b), .ce(ce), .power(power), .power_wr(power_wr),
		.boot_valid(boot_valid), .boot_power(boot_power), .fan_on_boot(fan_on_boot),
		.report_en(report_en), .failsafe_en(failsafe_en), .failsafe_cyc(failsafe_cyc),
		.glitch_cyc(glitch_cyc), .tach(tach), .sw_out(), .sw_oe(sw_oe), .report(report),
		.report_valid(report_valid), .failsafe_active(failsafe_active));
	for (genvar i = 0; i < 4; i++) begin : g_fan
		fpt_fan #(.HALF(7 + i)) fan_u (.clk(clk), .on(sw_oe[i]), .tach(tach[i]));
	end
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0][6:0] v);
		@(posedge clk);
		power <= v;
		power_wr <= 1'b1;
		@(posedge clk);
		power_wr <= 1'b0;
	endtask
	task automatic duty;
		int on [4] = '{0, 0, 0, 0};
		repeat (PWM) @(posedge clk);
		repeat (PWM) @(negedge clk) foreach (on[i]) on[i] += sw_oe[i];
		foreach (on[i]) chk(on[i], set_q[i] * PWM / 100);
	endtask
	initial begin
		logic [3:0][6:0] v;
		void'($urandom(32'h43EF58C9));
		glitch_cyc = 16'($urandom_range(30, 1));
		{rst_b, ce, power_wr, boot_valid} = 4'h4;
		{power, boot_power, report_en, failsafe_en, failsafe_cyc} = '0;
		fan_on_boot = 4'hF;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (200) @(posedge clk);
		set_q = '{100, 100, 100, 100};
		duty();
		for (int r = 0; r < 3; r++) begin
			foreach (set_q[i]) begin
				n = r ? $urandom_range(100, 20) : (i == 1 ? 127 : i * 33);
				v[i] = 7'(n);
				set_q[i] = n > 100 ? 100 : n;
			end
			wr(v);
			duty();
		end
		@(posedge clk);
		report_en <= 4'hF;
		wr('0);
		n = 0;
		repeat (4 * SLOT) @(negedge clk) n += sw_oe[0];
		chk(n > 0 && n <= 200, 1);
		repeat (4) begin
			n = 0;
			do @(negedge clk) n++; while (!report_valid && n < 1000);
			chk(report_valid, 1'b1);
			chk(report.fan, cyc / SLOT % 4);
			chk(report.cycles != 0, 1);
		end
		@(posedge clk);
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		ce <= 1'b1;
		report_en <= 4'h0;
		failsafe_en <= 4'h5;
		failsafe_cyc <= 32'h12C;
		wr('0);
		repeat (400) @(posedge clk);
		@(negedge clk);
		chk(failsafe_active, 4'h5);
		set_q = '{100, 0, 100, 0};
		duty();
		wr('0);
		@(negedge clk);
		chk(failsafe_active, 4'h0);
		@(posedge clk);
		rst_b <= 1'b0;
		{boot_valid, fan_on_boot, failsafe_cyc} <= {1'b1, 4'h5, 32'h0};
		foreach (set_q[i]) begin
			n = $urandom_range(100);
			boot_power[i] <= 7'(n);
			set_q[i] = i % 2 ? 0 : n;
		end
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (200) @(posedge clk);
		duty();
		wrap_up();
	end
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
